// [pma_array.v]
// Top of the macrocell array: fuse store, global bus, pins, test modes.
// Assumes an AXI4-Lite master on clk and pins that are asynchronous to it.
`timescale 1ns/1ps
`include "pma_map.vh"

// Behaviour
// - Preload clock pulse loads odd I/O levels into twelve selected registers.
// - Preload forces a register to the pin level regardless of configuration.
// - Observability shows second register on every output; enables stay under their own term.
// - Security bit blocks preload and observability entry.
// - Security bit makes every fuse location read as programmed, at once.
// - Pin-keepers are off by default and only on when enabled.
// - Active keepers hold the last driven level on undriven pins.
// - 24 macrocells, 17 product terms each, each an AND of 172 inputs.
// - Five dedicated terms: two clears, two clocks, one output enable.
// - Twelve terms ORed four at a time into three sum terms.
// - Eight shared presets serve groups of four then two macrocells.
// - Bus carries all 14 dedicated inputs true and complemented.
// - Each macrocell drives feedback, first register and pin, true and complement.
// - Feedback selects second register input sum or second register output.
// - All product terms take their inputs from the one shared global bus.
// - Legacy subset removes toggle mode, pin clocking and bypass feedback.
// - Power-up clears all registers; output level follows the polarity.
// - Each flip-flop is data or toggle type on its own.
// - Three sum terms merge into one of up to twelve terms.
// - Each flip-flop may take its clock from the clock input pin.
module pma_array (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AXI4-Lite write address and data
  input wire [14:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [14:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Dedicated inputs, bit 0 is also the pin clock
  input wire [13:0] ded_in,
  input wire [13:0] ded_driven,
  // I/O pins
  input wire [23:0] io_in,
  input wire [23:0] io_driven,
  output reg [23:0] io_out,
  output reg [23:0] io_oe,
  // Test pins
  input wire preload_entry,
  input wire preload_clk,
  input wire reg_select,
  input wire parity_select,
  input wire observe_entry
);

  reg [191:0] mask_mem [0:415];
  reg [7:0] mcfg_mem [0:23];
  reg [80:0] sync1_r;
  reg [80:0] sync2_r;
  reg [13:0] in_keep_r;
  reg [23:0] io_keep_r;
  reg [171:0] bus_r;
  reg [171:0] bus_nxt;
  reg pin_prev_r;
  reg plclk_prev_r;
  reg keep_en_r;
  reg legacy_r;
  reg secure_r;
  reg [14:0] aw_addr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_held_r;
  reg w_held_r;
  reg [31:0] rd_nxt;
  reg rd_err;
  reg wr_err;
  wire [13:0] in_s;
  wire [13:0] in_drv_s;
  wire [23:0] io_s;
  wire [23:0] io_drv_s;
  wire plent_s;
  wire plclk_s;
  wire qsel_s;
  wire psel_s;
  wire obs_s;
  wire [13:0] in_lvl;
  wire [23:0] io_lvl;
  wire [415:0] pt_all;
  wire [23:0] q1_v;
  wire [23:0] q2_v;
  wire [23:0] fb_v;
  wire [23:0] out_v;
  wire [23:0] oe_v;
  wire preload_act;
  wire observe_act;
  wire pl_pulse;
  wire pin_rise;
  wire do_write;
  wire [8:0] w_term;
  wire [2:0] w_word;
  wire [8:0] r_term;
  wire [2:0] r_word;
  wire [31:0] r_mask;
  integer i;
  integer b;

  // ----------------------------------------------------------------------
  // Pin synchronisers and keepers
  // ----------------------------------------------------------------------
  // Every pin passes two flip-flops before any logic looks at it.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= {`PMA_NSYNC{1'b0}};
      sync2_r <= {`PMA_NSYNC{1'b0}};
    end
    else
    begin
      sync1_r <= {observe_entry, parity_select, reg_select, preload_clk, preload_entry,
                  io_driven, io_in, ded_driven, ded_in};
      sync2_r <= sync1_r;
    end
  end

  assign in_s = sync2_r[13:0];
  assign in_drv_s = sync2_r[27:14];
  assign io_s = sync2_r[51:28];
  assign io_drv_s = sync2_r[75:52];
  assign plent_s = sync2_r[76];
  assign plclk_s = sync2_r[77];
  assign qsel_s = sync2_r[78];
  assign psel_s = sync2_r[79];
  assign obs_s = sync2_r[80];

  // Undriven pins read the kept level only while keepers are enabled.
  assign in_lvl = (in_drv_s | ~{14{keep_en_r}}) & in_s |
                  ~in_drv_s & {14{keep_en_r}} & in_keep_r;
  assign io_lvl = io_oe & io_out | ~io_oe & ((io_drv_s | ~{24{keep_en_r}}) & io_s |
                  ~io_drv_s & {24{keep_en_r}} & io_keep_r);

  // Keepers follow each pin while something drives it.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_keep_r <= 14'h0000;
      io_keep_r <= 24'h000000;
    end
    else
    begin
      in_keep_r <= in_drv_s & in_s | ~in_drv_s & in_keep_r;
      io_keep_r <= (io_drv_s | io_oe) & io_lvl | ~(io_drv_s | io_oe) & io_keep_r;
    end
  end

  // ----------------------------------------------------------------------
  // Global bus and product terms
  // ----------------------------------------------------------------------
  // The bus is registered so combinatorial feedback cannot form a loop.
  always @*
  begin
    bus_nxt = {`PMA_BUSW{1'b0}};
    for (i = 0; i < `PMA_NIN; i = i + 1)
    begin
      bus_nxt[2 * i] = in_lvl[i];
      bus_nxt[2 * i + 1] = ~in_lvl[i];
    end
    for (i = 0; i < `PMA_NMC; i = i + 1)
    begin
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i] = fb_v[i];
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i + 1] = ~fb_v[i];
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i + 2] = q1_v[i];
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i + 3] = ~q1_v[i];
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i + 4] = io_lvl[i];
      bus_nxt[`PMA_MC_BUS_BASE + 6 * i + 5] = ~io_lvl[i];
    end
  end

  // Each term is an AND of its connected bus bits; an empty term is false.
  genvar g;
  generate
    for (g = 0; g < 416; g = g + 1)
    begin : g_term
      assign pt_all[g] = (|mask_mem[g][171:0]) &
                         (&(~mask_mem[g][171:0] | bus_r));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Test modes
  // ----------------------------------------------------------------------
  // Entry pins only count while security is clear and the level is held.
  assign preload_act = plent_s & ~secure_r;
  assign observe_act = obs_s & ~secure_r;
  assign pl_pulse = preload_act & plclk_s & ~plclk_prev_r;
  assign pin_rise = in_s[0] & ~pin_prev_r;

  // ----------------------------------------------------------------------
  // Macrocells
  // ----------------------------------------------------------------------
  generate
    for (g = 0; g < `PMA_NMC; g = g + 1)
    begin : g_mc
      pma_macrocell u_mc (
        .clk(clk),
        .rst(rst),
        .pt(pt_all[g * 17 +: 17]),
        .preset(pt_all[`PMA_PRESET_BASE + (g / 6) * 2 + ((g % 6) / 4)]),
        .pin_rise(pin_rise),
        .cfg(mcfg_mem[g]),
        .legacy(legacy_r),
        .pl_load1(pl_pulse & ~qsel_s & (psel_s == (g % 2))),
        .pl_load2(pl_pulse & qsel_s & (psel_s == (g % 2))),
        .pl_data(io_s[(g / 2) * 2 + 1]),
        .q1(q1_v[g]),
        .q2(q2_v[g]),
        .fb(fb_v[g]),
        .out_lvl(out_v[g]),
        .oe(oe_v[g])
      );
    end
  endgenerate

  // Pins, bus and edge history.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      io_out <= 24'h000000;
      io_oe <= 24'h000000;
      bus_r <= {`PMA_BUSW{1'b0}};
      pin_prev_r <= 1'b0;
      plclk_prev_r <= 1'b0;
    end
    else
    begin
      io_out <= observe_act ? q2_v : out_v;
      io_oe <= oe_v;
      bus_r <= bus_nxt;
      pin_prev_r <= in_s[0];
      plclk_prev_r <= plclk_s;
    end
  end

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign w_term = aw_addr_r[13:5];
  assign w_word = aw_addr_r[4:2];
  assign r_term = s_axi_araddr[13:5];
  assign r_word = s_axi_araddr[4:2];
  assign r_mask = mask_mem[r_term][{r_word, 5'h00} +: 32];

  // Read decode; a secured device shows every fuse as programmed.
  always @*
  begin
    rd_nxt = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr[14])
    begin
      if (r_term < `PMA_NTERM && r_word < 3'h6)
        rd_nxt = secure_r ? `PMA_FUSE_READ :
                 (r_word == 3'h5 ? {20'h00000, r_mask[11:0]} : r_mask);
      else
        rd_err = 1'b1;
    end
    else if (s_axi_araddr[14:8] == `PMA_MCFG_PAGE && s_axi_araddr[7:2] < 6'h18)
      rd_nxt = secure_r ? `PMA_FUSE_READ : {24'h000000, mcfg_mem[s_axi_araddr[6:2]]};
    else if (s_axi_araddr == `PMA_CTRL_OFS)
      rd_nxt = {29'h00000000, secure_r, legacy_r, keep_en_r};
    else if (s_axi_araddr == `PMA_STAT_OFS)
      rd_nxt = {29'h00000000, secure_r, observe_act, preload_act};
    else if (s_axi_araddr == `PMA_Q1_OFS)
      rd_nxt = {8'h00, q1_v};
    else if (s_axi_araddr == `PMA_Q2_OFS)
      rd_nxt = {8'h00, q2_v};
    else
      rd_err = 1'b1;
  end

  // Write decode flags an unmapped address.
  always @*
  begin
    wr_err = 1'b1;
    if (aw_addr_r[14])
      wr_err = ~(w_term < `PMA_NTERM && w_word < 3'h6);
    else if (aw_addr_r[14:8] == `PMA_MCFG_PAGE && aw_addr_r[7:2] < 6'h18)
      wr_err = 1'b0;
    else if (aw_addr_r == `PMA_CTRL_OFS)
      wr_err = 1'b0;
  end

  // Bus handshakes, fuse store and control bits.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMA_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PMA_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_addr_r <= 15'h0000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      keep_en_r <= 1'b0;
      legacy_r <= 1'b0;
      secure_r <= 1'b0;
      for (b = 0; b < 416; b = b + 1)
        mask_mem[b] <= 192'h0;
      for (b = 0; b < `PMA_NMC; b = b + 1)
        mcfg_mem[b] <= `PMA_CFG_RESET;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_addr_r <= s_axi_awaddr;
        aw_held_r <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? `PMA_RESP_SLVERR : `PMA_RESP_OKAY;
        if (~wr_err && aw_addr_r[14])
        begin
          for (b = 0; b < 4; b = b + 1)
            if (wstrb_r[b])
              mask_mem[w_term][{w_word, 5'h00} + 8 * b +: 8] <= wdata_r[8 * b +: 8];
        end
        else if (~wr_err && aw_addr_r[14:8] == `PMA_MCFG_PAGE)
        begin
          if (wstrb_r[0])
            mcfg_mem[aw_addr_r[6:2]] <= wdata_r[7:0];
        end
        else if (~wr_err && wstrb_r[0])
        begin
          keep_en_r <= wdata_r[`PMA_CTRL_KEEP];
          legacy_r <= wdata_r[`PMA_CTRL_LEGACY];
          secure_r <= secure_r | wdata_r[`PMA_CTRL_SECURE];
        end
      end
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rd_err ? `PMA_RESP_SLVERR : `PMA_RESP_OKAY;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [pma_map.vh]
// Constants for the macrocell array: bus offsets, field positions, sizes.
// Included by the array top and the macrocell; holds definitions only.
`ifndef PMA_MAP_VH
`define PMA_MAP_VH

// ----------------------------------------------------------------------
// Array dimensions
// ----------------------------------------------------------------------
`define PMA_NMC 24
`define PMA_NPT 17
`define PMA_NIN 14
`define PMA_BUSW 172
`define PMA_NTERM 9'h1A0
`define PMA_NPRESET 8
`define PMA_PRESET_BASE 408
`define PMA_MC_BUS_BASE 28
`define PMA_NSYNC 81

// ----------------------------------------------------------------------
// Product term positions inside one macrocell
// ----------------------------------------------------------------------
`define PMA_PT_AR1 12
`define PMA_PT_CK1 13
`define PMA_PT_CK2 14
`define PMA_PT_AR2 15
`define PMA_PT_OE 16

// ----------------------------------------------------------------------
// Macrocell configuration word fields
// ----------------------------------------------------------------------
`define PMA_CFG_T1 0
`define PMA_CFG_T2 1
`define PMA_CFG_PINCK1 2
`define PMA_CFG_PINCK2 3
`define PMA_CFG_FB_Q2 4
`define PMA_CFG_COMBINE 5
`define PMA_CFG_OUT_COMB 6
`define PMA_CFG_POL 7
`define PMA_CFG_RESET 8'h00

// ----------------------------------------------------------------------
// Register map (byte addresses, 15-bit space)
// ----------------------------------------------------------------------
`define PMA_AW 15
`define PMA_CTRL_OFS 15'h0000
`define PMA_STAT_OFS 15'h0004
`define PMA_Q1_OFS 15'h0008
`define PMA_Q2_OFS 15'h000C
`define PMA_MCFG_PAGE 7'h01
`define PMA_CTRL_KEEP 0
`define PMA_CTRL_LEGACY 1
`define PMA_CTRL_SECURE 2
`define PMA_RESP_OKAY 2'h0
`define PMA_RESP_SLVERR 2'h2
`define PMA_FUSE_READ 32'hFFFFFFFF

`endif

// [pma_macrocell.v]
// One macrocell: sum terms, two flip-flops, feedback and output selection.
// Assumes its product terms come from the shared array of the top level.
`timescale 1ns/1ps
`include "pma_map.vh"

module pma_macrocell (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Array terms
  input wire [16:0] pt,
  input wire preset,
  input wire pin_rise,
  // Configuration
  input wire [7:0] cfg,
  input wire legacy,
  // Preload
  input wire pl_load1,
  input wire pl_load2,
  input wire pl_data,
  // State out
  output wire q1,
  output wire q2,
  output wire fb,
  output wire out_lvl,
  output wire oe
);

  reg q1_r;
  reg q2_r;
  reg ck1_prev_r;
  reg ck2_prev_r;
  reg q1_nxt;
  reg q2_nxt;
  wire all_sum;
  wire d1;
  wire d2;
  wire d3;
  wire t1;
  wire t2;
  wire pck1;
  wire pck2;
  wire rise1;
  wire rise2;

  // ----------------------------------------------------------------------
  // Sum terms
  // ----------------------------------------------------------------------
  // Four terms per sum, or all twelve merged into each sum.
  assign all_sum = |pt[11:0];
  assign d1 = cfg[`PMA_CFG_COMBINE] ? all_sum : |pt[3:0];
  assign d2 = cfg[`PMA_CFG_COMBINE] ? all_sum : |pt[7:4];
  assign d3 = cfg[`PMA_CFG_COMBINE] ? all_sum : |pt[11:8];

  // Legacy subset removes toggle mode, pin clocking and bypass feedback.
  assign t1 = cfg[`PMA_CFG_T1] & ~legacy;
  assign t2 = cfg[`PMA_CFG_T2] & ~legacy;
  assign pck1 = cfg[`PMA_CFG_PINCK1] & ~legacy;
  assign pck2 = cfg[`PMA_CFG_PINCK2] & ~legacy;

  // Active clock edge: pin clock rise or rising edge of the clock term.
  assign rise1 = pck1 ? pin_rise : (pt[`PMA_PT_CK1] & ~ck1_prev_r);
  assign rise2 = pck2 ? pin_rise : (pt[`PMA_PT_CK2] & ~ck2_prev_r);

  // ----------------------------------------------------------------------
  // Flip-flop next state
  // ----------------------------------------------------------------------
  // Preload wins, then the clear term, then preset, then the sum term.
  always @*
  begin
    q1_nxt = q1_r;
    if (pl_load1)
      q1_nxt = pl_data;
    else if (pt[`PMA_PT_AR1])
      q1_nxt = 1'b0;
    else if (rise1)
    begin
      if (preset)
        q1_nxt = 1'b1;
      else if (t1)
        q1_nxt = q1_r ^ d1;
      else
        q1_nxt = d1;
    end
    q2_nxt = q2_r;
    if (pl_load2)
      q2_nxt = pl_data;
    else if (pt[`PMA_PT_AR2])
      q2_nxt = 1'b0;
    else if (rise2)
    begin
      if (preset)
        q2_nxt = 1'b1;
      else if (t2)
        q2_nxt = q2_r ^ d2;
      else
        q2_nxt = d2;
    end
  end

  // Registers clear at power-up.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q1_r <= 1'b0;
      q2_r <= 1'b0;
      ck1_prev_r <= 1'b0;
      ck2_prev_r <= 1'b0;
    end
    else
    begin
      q1_r <= q1_nxt;
      q2_r <= q2_nxt;
      ck1_prev_r <= pt[`PMA_PT_CK1];
      ck2_prev_r <= pt[`PMA_PT_CK2];
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Feedback carries the second register or its input sum.
  assign fb = (cfg[`PMA_CFG_FB_Q2] | legacy) ? q2_r : d2;
  assign out_lvl = (cfg[`PMA_CFG_OUT_COMB] ? d3 : q1_r) ^ cfg[`PMA_CFG_POL];
  assign oe = pt[`PMA_PT_OE];
  assign q1 = q1_r;
  assign q2 = q2_r;

endmodule

// [pma_sva.sv]
// Checker for the macrocell array top: bus handshakes and reset levels.
// Assumes it is bound to the array top and sees only its ports.
`timescale 1ns/1ps

module pma_sva (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins
  input wire [23:0] io_out,
  input wire [23:0] io_oe
);
  // ----------------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Both halves of a write taken at one edge.
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // A read address taken.
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_reset_quiet;
    $fell(rst) |-> io_out == 24'h000000 && io_oe == 24'h000000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins not low after reset");
  property p_wr_answer;
    s_wr_take |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data repeated");
  property p_aw_pulse;
    s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");
  property p_ar_pulse;
    s_axi_arready |=> !s_axi_arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready longer than a cycle");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h00000000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read carries data");
  property p_ar_idle;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_idle: assert property (p_ar_idle) else $error("read taken while data pending");
endmodule

// [pma_pins.sv]
// Board and tester model: drives the input pins and the test pins.
// Assumes one bench process calls its tasks; all lines stay driven.
`timescale 1ns/1ps

module pma_pins (
  // Clock
  input wire clk,
  // Input pins
  output reg [13:0] ded_in,
  output reg [13:0] ded_driven,
  output reg [23:0] io_in,
  output reg [23:0] io_driven,
  // Test pins
  output reg preload_entry,
  output reg preload_clk,
  output reg reg_select,
  output reg parity_select,
  output reg observe_entry
);
  // Idle levels: every pin driven low, test modes off.
  initial
  begin
    ded_in = 14'h0000;
    ded_driven = 14'h3FFF;
    io_in = 24'h000000;
    io_driven = 24'hFFFFFF;
    preload_entry = 1'b0;
    preload_clk = 1'b0;
    reg_select = 1'b0;
    parity_select = 1'b0;
    observe_entry = 1'b0;
  end

  // One preload cycle; entry stays up around the whole clock pulse.
  task preload(input r, input p, input [23:0] v);
    begin
      @(posedge clk);
      preload_entry <= 1'b1;
      reg_select <= r;
      parity_select <= p;
      io_in <= v;
      repeat (4) @(posedge clk);
      preload_clk <= 1'b1;
      repeat (4) @(posedge clk);
      preload_clk <= 1'b0;
      repeat (4) @(posedge clk);
      preload_entry <= 1'b0;
    end
  endtask

  // Observability entry level.
  task observe(input e);
    begin
      @(posedge clk);
      observe_entry <= e;
    end
  endtask
endmodule

// [pld_macrocell_array_preload_bench.sv]
// Self-checking bench: preload table, observability, clear term, security.
// Assumes the array top, its checker and the pin model in one folder.
`timescale 1ns/1ps
`include "pma_map.vh"

module pld_macrocell_array_preload_bench;
  reg clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg [14:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [13:0] ded_in, ded_driven;
  wire [23:0] io_in, io_driven, io_out, io_oe;
  wire preload_entry, preload_clk, reg_select, parity_select, observe_entry;
  integer errors, n_compared, seed, cyc, i, m, tmp;
  reg [23:0] q1_m, q2_m, v;

  // ----------------------------------------------------------------------
  // Instances and clock
  // ----------------------------------------------------------------------
  pma_array dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ded_in, .ded_driven, .io_in, .io_driven, .io_out, .io_oe,
    .preload_entry, .preload_clk, .reg_select, .parity_select, .observe_entry);
  pma_pins pins_u (.clk, .ded_in, .ded_driven, .io_in, .io_driven, .preload_entry,
    .preload_clk, .reg_select, .parity_select, .observe_entry);

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp)
        errors = errors + 1;
    end
  endtask

  // Write: address and data offered together, each dropped once taken.
  task axi_wr(input [14:0] a, input [31:0] d, input [1:0] r);
    reg ah, wh, bh;
    reg [1:0] got;
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bh = 1'b0;
      while (!bh)
      begin
        @(negedge clk);
        ah = s_axi_awready;
        wh = s_axi_wready;
        bh = s_axi_bvalid;
        got = s_axi_bresp;
        @(posedge clk);
        if (ah) s_axi_awvalid <= 1'b0;
        if (wh) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk({30'h0, got}, {30'h0, r});
    end
  endtask

  // Read: data and response captured while rvalid stands.
  task axi_rd(input [14:0] a, input [31:0] d, input [1:0] r);
    reg h;
    reg [31:0] gd;
    reg [1:0] gr;
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      h = 1'b0;
      while (!h)
      begin
        @(negedge clk);
        h = s_axi_arready;
        @(posedge clk);
      end
      s_axi_arvalid <= 1'b0;
      h = 1'b0;
      while (!h)
      begin
        @(negedge clk);
        h = s_axi_rvalid;
        gd = s_axi_rdata;
        gr = s_axi_rresp;
        @(posedge clk);
      end
      s_axi_rready <= 1'b0;
      chk({30'h0, gr}, {30'h0, r});
      chk(gd, d);
    end
  endtask

  // Reference preload: parity picks macrocells, select picks the register.
  task pre(input r, input p, input [23:0] d);
    begin
      pins_u.preload(r, p, d);
      for (m = 0; m < 24; m = m + 1)
        if ((m % 2) == p && r)
          q2_m[m] = d[2 * (m / 2) + 1];
        else if ((m % 2) == p)
          q1_m[m] = d[2 * (m / 2) + 1];
    end
  endtask

  task test_done;
    begin
      if (errors == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Hang guard.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      test_done;
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 15'h0000;
    s_axi_araddr = 15'h0000;
    s_axi_wdata = 32'h00000000;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    seed = 24761;
    q1_m = 24'h000000;
    q2_m = 24'h000000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axi_rd(`PMA_CTRL_OFS, 32'h0, `PMA_RESP_OKAY);
    axi_rd(`PMA_Q1_OFS, 32'h0, `PMA_RESP_OKAY);
    axi_rd(`PMA_Q2_OFS, 32'h0, `PMA_RESP_OKAY);
    axi_rd(15'h0010, 32'h0, `PMA_RESP_SLVERR);
    axi_wr(15'h0010, 32'h1, `PMA_RESP_SLVERR);
    axi_wr(`PMA_CTRL_OFS, 32'h1, `PMA_RESP_OKAY);
    axi_rd(`PMA_CTRL_OFS, 32'h1, `PMA_RESP_OKAY);
    for (i = 0; i < 4; i = i + 1)
    begin
      tmp = $random(seed);
      v = tmp[23:0];
      pre(i[0], i[1], v);
      axi_rd(`PMA_Q1_OFS, {8'h00, q1_m}, `PMA_RESP_OKAY);
      axi_rd(`PMA_Q2_OFS, {8'h00, q2_m}, `PMA_RESP_OKAY);
    end
    pins_u.observe(1'b1);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({8'h00, io_out}, {8'h00, q2_m});
    chk({8'h00, io_oe}, 32'h0);
    pins_u.observe(1'b0);
    pre(1'b0, 1'b0, 24'hFFFFFF);
    // Clear term of macrocell 4 (term 80) on the inverted input 1, which is always true.
    axi_wr(15'h4A00, 32'h8, `PMA_RESP_OKAY);
    q1_m[4] = 1'b0;
    repeat (10) @(posedge clk);
    axi_rd(15'h4A00, 32'h8, `PMA_RESP_OKAY);
    axi_rd(`PMA_Q1_OFS, {8'h00, q1_m}, `PMA_RESP_OKAY);
    axi_wr(`PMA_CTRL_OFS, 32'h5, `PMA_RESP_OKAY);
    pins_u.observe(1'b1);
    axi_rd(`PMA_STAT_OFS, 32'h4, `PMA_RESP_OKAY);
    axi_rd(15'h4A00, `PMA_FUSE_READ, `PMA_RESP_OKAY);
    pins_u.preload(1'b1, 1'b1, 24'h000000);
    axi_rd(`PMA_Q2_OFS, {8'h00, q2_m}, `PMA_RESP_OKAY);
    @(negedge clk);
    chk({8'h00, io_out}, {8'h00, q1_m});
    test_done;
  end
endmodule

bind pma_array pma_sva chk_u (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .io_out, .io_oe);
